//--- tb_uart_fifo_flow_line_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_flow_line_config;
    import ufc_pkg::*;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    ufc_req_s req = '0;
    logic special_feature_bit2 = 1'b0;
    logic txd_shift = 1'b1;
    logic rx_fifo_high = 1'b0;
    logic send_pause = 1'b0;
    logic send_resume = 1'b0;
    logic flow_taken = 1'b0;
    wire logic rx_valid;
    wire logic [7:0] rx_char;
    wire logic cts_n_pin;
    logic [7:0] rd_data_r, store_char_r, flow_char_r;
    logic store_valid_r, flow_valid_r, txd_r, rts_n_r, tx_hold_r, sleep_ok_r;
    logic [6:0] fifo_depth_r;
    logic [5:0] rx_trig_r, tx_trig_r;
    logic [15:0] divisor_r;
    logic rx_clr, tx_clr;
    int err_count = 0;
    int check_count = 0;
    int store_cnt = 0;
    int base;
    logic [7:0] last_store = 8'h00;
    logic [7:0] got;
    // pauses before resumes, so each table pass leaves the pause flag clear
    logic [7:0] ch [5] = '{8'h13, 8'h14, 8'h11, 8'h12, 8'h55};
    logic [3:0] rx_sel [5] = '{4'h0, 4'h2, 4'h1, 4'hb, 4'h7};
    logic [4:0] rx_hit [5] = '{5'h00, 5'h05, 5'h0a, 5'h0f, 5'h0f};

    always #2 clk_sys = ~clk_sys;

    ufc_top i_ufc_top
    (
        .clk_sys(clk_sys), .rst(rst), .req(req), .special_feature_bit2(special_feature_bit2),
        .rx_valid(rx_valid), .rx_char(rx_char), .txd_shift(txd_shift), .cts_n_pin(cts_n_pin),
        .rx_fifo_high(rx_fifo_high), .send_pause(send_pause), .send_resume(send_resume),
        .flow_taken(flow_taken), .rd_data_r(rd_data_r), .store_valid_r(store_valid_r),
        .store_char_r(store_char_r), .flow_valid_r(flow_valid_r), .flow_char_r(flow_char_r),
        .txd_r(txd_r), .rts_n_r(rts_n_r), .tx_hold_r(tx_hold_r), .fifo_depth_r(fifo_depth_r),
        .rx_trig_r(rx_trig_r), .tx_trig_r(tx_trig_r), .rx_fifo_clr_r(rx_clr), .tx_fifo_clr_r(tx_clr),
        .divisor_r(divisor_r), .sleep_ok_r(sleep_ok_r)
    );
    ufc_remote_station i_ufc_remote_station
    (
        .clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_char(rx_char), .cts_n_pin(cts_n_pin)
    );

    always @(posedge clk_sys)
    begin
        if (store_valid_r === 1'b1)
        begin
            store_cnt++;
            last_store = store_char_r;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] act);
        check_count++;
        if (act !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, act);
            err_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        req <= '0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        req <= '0;
        tick(1);
        got = rd_data_r;
    endtask
    task automatic set_efr(input logic [7:0] v);
        wr(3'h3, 8'hbf);
        wr(3'h2, v);
        wr(3'h3, 8'h00);
    endtask
    task automatic rx_try(input logic [7:0] c, input int exp);
        int n;
        n = store_cnt;
        i_ufc_remote_station.send_char(c);
        tick(3);
        chk("stored", 16'(exp), 16'(store_cnt - n));
    endtask
    task automatic flow_check(input logic pz, input int n, input logic [7:0] e0, input logic [7:0] e1);
        int w;
        @(posedge clk_sys);
        send_pause <= pz;
        send_resume <= !pz;
        @(posedge clk_sys);
        send_pause <= 1'b0;
        send_resume <= 1'b0;
        for (int k = 0; k < n; k++)
        begin
            w = 0;
            do
            begin
                tick(1);
                w++;
            end while (flow_valid_r !== 1'b1 && w < 20);
            if (flow_valid_r !== 1'b1)
            begin
                err_count++;
                end_sim();
            end
            chk("flow char", (k == 0) ? e0 : e1, flow_char_r);
            @(posedge clk_sys);
            flow_taken <= 1'b1;
            @(posedge clk_sys);
            flow_taken <= 1'b0;
            @(posedge clk_sys);
        end
        tick(4);
        chk("flow idle", 16'h0, flow_valid_r);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(3'h3);
        chk("line_control", 16'h1d, got);
        chk("depth", 16'h1, fifo_depth_r);
        wr(3'h1, 8'h10);
        tick(2);
        chk("sleep", 16'h0, sleep_ok_r);
        wr(3'h2, 8'h31);
        tick(2);
        chk("depth", 16'h40, fifo_depth_r);
        chk("rx trig", 16'h8, rx_trig_r);
        chk("tx trig", 16'h8, tx_trig_r);
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'hd0);
        rd(3'h2);
        chk("enhanced", 16'hd0, got);
        @(posedge clk_sys);
        special_feature_bit2 <= 1'b1;
        wr(3'h2, 8'h00);
        @(posedge clk_sys);
        special_feature_bit2 <= 1'b0;
        rd(3'h2);
        chk("enhanced", 16'hd0, got);
        for (int i = 0; i < 4; i++)
            wr(3'(4 + i), 8'(8'h11 + i));
        i_ufc_remote_station.set_stall(1'b1);
        tick(8);
        chk("tx hold", 16'h1, tx_hold_r);
        i_ufc_remote_station.set_stall(1'b0);
        tick(8);
        chk("tx hold", 16'h0, tx_hold_r);
        chk("rts", 16'h0, rts_n_r);
        @(posedge clk_sys);
        rx_fifo_high <= 1'b1;
        tick(4);
        chk("rts", 16'h1, rts_n_r);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h31);
        wr(3'h1, 8'h10);
        tick(2);
        chk("tx trig", 16'd56, tx_trig_r);
        chk("sleep", 16'h1, sleep_ok_r);
        wr(3'h2, 8'hc7);
        #1;
        chk("rx clr", 16'h1, rx_clr);
        chk("tx clr", 16'h1, tx_clr);
        tick(2);
        chk("rx trig", 16'h3c, rx_trig_r);
        wr(3'h2, 8'h00);
        tick(2);
        chk("depth", 16'h1, fifo_depth_r);
        chk("rx trig", 16'h1, rx_trig_r);
        chk("tx trig", 16'h1, tx_trig_r);
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        tick(1);
        chk("divisor", 16'h1234, divisor_r);
        wr(3'h3, 8'hbf);
        wr(3'h1, 8'h77);
        tick(1);
        chk("divisor", 16'h1234, divisor_r);
        wr(3'h3, 8'h40);
        tick(3);
        chk("txd", 16'h0, txd_r);
        wr(3'h3, 8'h00);
        tick(3);
        chk("txd", 16'h1, txd_r);
        for (int s = 0; s < 5; s++)
        begin
            set_efr({4'h1, rx_sel[s]});
            for (int i = 0; i < 5; i++)
                rx_try(ch[i], int'(!rx_hit[s][i]));
        end
        set_efr(8'h30);
        rx_try(8'h14, 1);
        chk("stored char", 16'h14, last_store);
        rd(3'h2);
        chk("ident", 16'h10, got);
        rd(3'h2);
        chk("ident", 16'h01, got);
        set_efr(8'h31);
        rx_try(8'h14, 0);
        rd(3'h2);
        rd(3'h2);
        chk("ident", 16'h10, got);
        rx_try(8'h12, 0);
        rd(3'h2);
        chk("ident", 16'h01, got);
        set_efr(8'h13);
        base = store_cnt;
        i_ufc_remote_station.send_pair(8'h13, 8'h14);
        tick(3);
        rd(3'h2);
        chk("ident", 16'h10, got);
        i_ufc_remote_station.send_pair(8'h11, 8'h12);
        tick(3);
        rd(3'h2);
        chk("ident", 16'h01, got);
        i_ufc_remote_station.send_pair(8'h13, 8'h55);
        tick(4);
        chk("stored", 16'h2, 16'(store_cnt - base));
        for (int t = 0; t < 4; t++)
        begin
            set_efr({4'h1, 2'(t), 2'b00});
            flow_check(1'b1, (t == 0) ? 0 : ((t == 3) ? 2 : 1), (t == 1) ? 8'h14 : 8'h13, 8'h14);
        end
        flow_check(1'b0, 2, 8'h11, 8'h12);
        end_sim();
    end
endmodule
`default_nettype wire

//--- ufc_cfg.svh
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
`define UFC_OFF_DIV_LO 3'h0
`define UFC_OFF_DIV_HI 3'h1
`define UFC_OFF_INT_EN 3'h1
`define UFC_OFF_FIFO_CTL 3'h2
`define UFC_OFF_LINE_CTL 3'h3
`define UFC_OFF_MODEM_CTL 3'h4
`define UFC_OFF_TRIG_CTL 3'h6
`define UFC_OFF_TRIG_LVL 3'h7
`define UFC_OFF_RES1 3'h4
`define UFC_OFF_RES2 3'h5
`define UFC_OFF_PAU1 3'h6
`define UFC_OFF_PAU2 3'h7
`define UFC_ENH_KEY 8'hbf
`define UFC_LINE_RST 8'h1d
`define UFC_IDENT_IDLE 6'h01
`define UFC_IDENT_XOFF 6'h10
`define UFC_DEPTH_ON 7'h40
`define UFC_DEPTH_OFF 7'h01
`endif

//--- ufc_pkg.sv
package ufc_pkg;
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufc_req_s;
    typedef struct packed
    {
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
    } ufc_chars_s;
    typedef enum logic [1:0] {UFC_TX_IDLE, UFC_TX_FIRST, UFC_TX_SECOND} ufc_txst_e;
endpackage

//--- ufc_remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_remote_station
(
    input wire logic clk_sys,
    input wire logic rst,
    output logic rx_valid,
    output logic [7:0] rx_char,
    output logic cts_n_pin
);
    // ----------------------------------------
    // remote serial station
    // ----------------------------------------
    initial
    begin
        rx_valid = 1'b0;
        rx_char = 8'h5a;
        cts_n_pin = 1'b0;
    end
    // idle data shows the inverse of the last char, so a stale value never matches
    task automatic send_char(input logic [7:0] c);
        @(posedge clk_sys);
        rx_valid <= !rst;
        rx_char <= c;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_char <= ~c;
    endtask
    task automatic send_pair(input logic [7:0] a, input logic [7:0] b);
        send_char(a);
        send_char(b);
    endtask
    task automatic set_stall(input logic s);
        @(posedge clk_sys);
        cts_n_pin <= s;
    endtask
endmodule
`default_nettype wire

//--- ufc_rx_flow.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_rx_flow
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spec_en,
    input wire logic [3:0] sel,
    input wire ufc_pkg::ufc_chars_s chars,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    output logic store_valid_r,
    output logic [7:0] store_char_r,
    output logic xoff_hit_r,
    output logic xon_hit_r,
    output logic special_hit_r
);
    import ufc_pkg::*;
    logic pend_r, pend_off_r, replay_r;
    logic [7:0] pend_c_r, replay_c_r;
    wire cur_v = replay_r | rx_valid;
    wire [7:0] cur = replay_r ? replay_c_r : rx_char;
    // double pairs only when both transmit bits agree
    wire dbl = (sel[1:0] == 2'b11) & (sel[3] == sel[2]);
    wire on1 = !dbl & ((sel[1] & cur == chars.resume1) | (sel[0] & cur == chars.resume2));
    wire off1 = !dbl & ((sel[1] & cur == chars.pause1) | (sel[0] & cur == chars.pause2));
    wire is_p2 = cur == chars.pause2;
    wire first = dbl & (cur == chars.resume1 | cur == chars.pause1);
    wire second_ok = cur == (pend_off_r ? chars.pause2 : chars.resume2);
    // ---------------------------------------------
    // receive compare
    // ---------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        store_valid_r <= 1'b0;
        xoff_hit_r <= 1'b0;
        xon_hit_r <= 1'b0;
        special_hit_r <= 1'b0;
        replay_r <= 1'b0;
        if (rst)
        begin
            pend_r <= 1'b0;
            pend_off_r <= 1'b0;
            pend_c_r <= 8'h00;
            replay_c_r <= 8'h00;
            store_char_r <= 8'h00;
        end
        else if (cur_v)
        begin
            if (pend_r)
            begin
                pend_r <= 1'b0;
                if (second_ok)
                begin
                    xoff_hit_r <= pend_off_r;
                    xon_hit_r <= !pend_off_r;
                    special_hit_r <= spec_en & pend_off_r;
                end
                else
                begin
                    // broken pair: keep the first, re-run the new one
                    store_valid_r <= 1'b1;
                    store_char_r <= pend_c_r;
                    replay_r <= 1'b1;
                    replay_c_r <= cur;
                end
            end
            else if (first)
            begin
                pend_r <= 1'b1;
                pend_off_r <= cur == chars.pause1;
                pend_c_r <= cur;
            end
            else if (off1)
            begin
                xoff_hit_r <= 1'b1;
                special_hit_r <= spec_en & is_p2;
            end
            else if (on1)
                xon_hit_r <= 1'b1;
            else
            begin
                store_valid_r <= 1'b1;
                store_char_r <= cur;
                special_hit_r <= spec_en & is_p2;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_spec_kept: assert property (rx_valid && !replay_r && !pend_r && spec_en && sel[1:0] == 2'b00
        && rx_char == chars.pause2 |=> store_valid_r && special_hit_r)
        else $error("special char not stored and flagged");
    a_pause2_drop: assert property (rx_valid && !replay_r && !pend_r && spec_en && sel == 4'b0001
        && rx_char == chars.pause2 |=> !store_valid_r && xoff_hit_r && special_hit_r)
        else $error("compared pause char reached fifo");
endmodule
`default_nettype wire

//--- ufc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufc_cfg.svh"
// Functional notes
// - fifo off: single char, locked, trigger one
// - fifo on: both fifos hold 64
// - transmit trigger writes need unlock bit
// - enhanced register only at key, feature bit2 clear
// - bit 7 enables cts transmit hold
// - bit 6 enables automatic rts
// - second pause char stored, flag raised
// - compared second pause: dropped, both flags; here only the pause flag is set, the special flag is masked
// - unlock bit gates upper fields, sleep
// - bits 3:2 pick transmitted flow chars
// - bits 1:0 pick receive compare pair
// - single-pair send, receiver accepts either
// - both pairs sent or compared doubled
// - line control bit 7 maps divisor latches
// - line control bit 6 forces line low
// - divisor high needs bit7, not key
// - flag clears on resume or read
module ufc_top
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire ufc_pkg::ufc_req_s req,
    input wire logic special_feature_bit2,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic txd_shift,
    input wire logic cts_n_pin,
    input wire logic rx_fifo_high,
    input wire logic send_pause,
    input wire logic send_resume,
    input wire logic flow_taken,
    output logic [7:0] rd_data_r,
    output logic store_valid_r,
    output logic [7:0] store_char_r,
    output logic flow_valid_r,
    output logic [7:0] flow_char_r,
    output logic txd_r,
    output logic rts_n_r,
    output logic tx_hold_r,
    output logic [6:0] fifo_depth_r,
    output logic [5:0] rx_trig_r,
    output logic [5:0] tx_trig_r,
    output logic rx_fifo_clr_r,
    output logic tx_fifo_clr_r,
    output logic [15:0] divisor_r,
    output logic sleep_ok_r
);
    import ufc_pkg::*;

    // ---------------------------------------------
    // register state
    // ---------------------------------------------
    logic [7:0] line_control_r, enhanced_features_r, interrupt_enable_r, modem_control_r;
    logic [7:0] trigger_control_r, trigger_level_r;
    logic fifo_en_r;
    logic [1:0] rx_code_r, tx_code_r;
    logic xoff_flag_r, spec_flag_r;
    ufc_chars_s chars_r;
    logic [2:0] cts_sync_r;
    logic cts_n_r;
    logic xoff_hit, xon_hit, special_hit;

    function automatic logic [5:0] rx_level(input logic [1:0] c);
        rx_level = (c == 2'b00) ? 6'h08 : (c == 2'b01) ? 6'h10 : (c == 2'b10) ? 6'h38 : 6'h3c;
    endfunction

    function automatic logic [5:0] tx_level(input logic [1:0] c);
        tx_level = (c == 2'b00) ? 6'h08 : (c == 2'b01) ? 6'h10 : (c == 2'b10) ? 6'h20 : 6'h38;
    endfunction

    // ---------------------------------------------
    // address decode
    // ---------------------------------------------
    wire key = line_control_r == `UFC_ENH_KEY;
    wire dl_sel = line_control_r[7] & !key;
    wire norm = !line_control_r[7];
    wire enh_acc = key & !special_feature_bit2;
    wire unlock = enhanced_features_r[4];
    wire [7:0] wd = req.wdata;
    wire wr_line = req.wr & req.addr == `UFC_OFF_LINE_CTL;
    wire wr_div_lo = req.wr & dl_sel & req.addr == `UFC_OFF_DIV_LO;
    wire wr_div_hi = req.wr & dl_sel & req.addr == `UFC_OFF_DIV_HI;
    wire wr_int_en = req.wr & norm & req.addr == `UFC_OFF_INT_EN;
    wire wr_fifo = req.wr & norm & req.addr == `UFC_OFF_FIFO_CTL;
    wire wr_enh = req.wr & enh_acc & req.addr == `UFC_OFF_FIFO_CTL;
    wire wr_modem = req.wr & norm & req.addr == `UFC_OFF_MODEM_CTL;
    wire trig_sel = norm & modem_control_r[2];
    wire wr_trig_ctl = req.wr & trig_sel & unlock & req.addr == `UFC_OFF_TRIG_CTL;
    wire wr_trig_lvl = req.wr & trig_sel & unlock & req.addr == `UFC_OFF_TRIG_LVL;
    wire wr_chr = req.wr & key & req.addr >= `UFC_OFF_RES1;
    wire rd_ident = req.rd & norm & req.addr == `UFC_OFF_FIFO_CTL;
    wire flag_on = unlock & (xoff_flag_r | spec_flag_r);
    wire [7:0] ident = {fifo_en_r, fifo_en_r, flag_on ? `UFC_IDENT_XOFF : `UFC_IDENT_IDLE};

    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        case (req.addr)
            `UFC_OFF_DIV_LO: rd_mux = dl_sel ? divisor_r[7:0] : 8'h00;
            `UFC_OFF_DIV_HI: rd_mux = dl_sel ? divisor_r[15:8] : (norm ? interrupt_enable_r : 8'h00);
            `UFC_OFF_FIFO_CTL: rd_mux = enh_acc ? enhanced_features_r : (norm ? ident : 8'h00);
            `UFC_OFF_LINE_CTL: rd_mux = line_control_r;
            `UFC_OFF_RES1: rd_mux = key ? chars_r.resume1 : (norm ? modem_control_r : 8'h00);
            `UFC_OFF_RES2: rd_mux = key ? chars_r.resume2 : 8'h00;
            `UFC_OFF_PAU1: rd_mux = key ? chars_r.pause1 : (trig_sel ? trigger_control_r : 8'h00);
            `UFC_OFF_PAU2: rd_mux = key ? chars_r.pause2 : (trig_sel ? trigger_level_r : 8'h00);
            default: rd_mux = 8'h00;
        endcase
    end

    // ---------------------------------------------
    // register writes
    // ---------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            line_control_r <= `UFC_LINE_RST;
            enhanced_features_r <= 8'h00;
            interrupt_enable_r <= 8'h00;
            modem_control_r <= 8'h00;
            trigger_control_r <= 8'h00;
            trigger_level_r <= 8'h00;
            divisor_r <= 16'h0000;
            chars_r <= 32'h0000_0000;
            rd_data_r <= 8'h00;
        end
        else
        begin
            rd_data_r <= req.rd ? rd_mux : rd_data_r;
            if (wr_line)
                line_control_r <= wd;
            if (wr_enh)
                enhanced_features_r <= wd;
            if (wr_div_lo)
                divisor_r[7:0] <= wd;
            if (wr_div_hi)
                divisor_r[15:8] <= wd;
            if (wr_int_en)
                interrupt_enable_r <= {unlock ? wd[7:4] : interrupt_enable_r[7:4], wd[3:0]};
            if (wr_modem)
                modem_control_r <= {unlock ? wd[7:5] : modem_control_r[7:5], wd[4:0]};
            if (wr_trig_ctl)
                trigger_control_r <= wd;
            if (wr_trig_lvl)
                trigger_level_r <= wd;
            if (wr_chr)
            begin
                case (req.addr)
                    `UFC_OFF_RES1: chars_r.resume1 <= wd;
                    `UFC_OFF_RES2: chars_r.resume2 <= wd;
                    `UFC_OFF_PAU1: chars_r.pause1 <= wd;
                    default: chars_r.pause2 <= wd;
                endcase
            end
        end
    end

    // ---------------------------------------------
    // fifo control
    // ---------------------------------------------
    // with the fifo off only the enable bit is live; others keep their value
    always_ff @(posedge clk_sys)
    begin
        rx_fifo_clr_r <= wr_fifo & wd[0] & wd[1];
        tx_fifo_clr_r <= wr_fifo & wd[0] & wd[2];
        if (rst)
        begin
            fifo_en_r <= 1'b0;
            rx_code_r <= 2'b00;
            tx_code_r <= 2'b00;
            rx_fifo_clr_r <= 1'b0;
            tx_fifo_clr_r <= 1'b0;
        end
        else if (wr_fifo)
        begin
            fifo_en_r <= wd[0];
            if (wd[0])
            begin
                rx_code_r <= wd[7:6];
                if (unlock)
                    tx_code_r <= wd[5:4];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fifo_depth_r <= `UFC_DEPTH_OFF;
            rx_trig_r <= 6'h01;
            tx_trig_r <= 6'h01;
        end
        else
        begin
            fifo_depth_r <= fifo_en_r ? `UFC_DEPTH_ON : `UFC_DEPTH_OFF;
            rx_trig_r <= fifo_en_r ? rx_level(rx_code_r) : 6'h01;
            tx_trig_r <= fifo_en_r ? tx_level(tx_code_r) : 6'h01;
        end
    end

    // ---------------------------------------------
    // line pins and flow flags
    // ---------------------------------------------
    // cts is async: three flops, a change counts when the last two agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cts_sync_r <= 3'b111;
            cts_n_r <= 1'b1;
            txd_r <= 1'b1;
            rts_n_r <= 1'b1;
            tx_hold_r <= 1'b0;
            sleep_ok_r <= 1'b0;
            xoff_flag_r <= 1'b0;
            spec_flag_r <= 1'b0;
        end
        else
        begin
            cts_sync_r <= {cts_sync_r[1:0], cts_n_pin};
            if (cts_sync_r[1] == cts_sync_r[2])
                cts_n_r <= cts_sync_r[2];
            txd_r <= line_control_r[6] ? 1'b0 : txd_shift;
            tx_hold_r <= enhanced_features_r[7] & cts_n_r;
            rts_n_r <= enhanced_features_r[6] ? rx_fifo_high : !modem_control_r[1];
            sleep_ok_r <= unlock & interrupt_enable_r[4];
            // a new event in the clearing cycle wins
            xoff_flag_r <= xoff_hit | (xoff_flag_r & !xon_hit);
            spec_flag_r <= (special_hit & !xoff_hit) | (spec_flag_r & !rd_ident);
        end
    end

    ufc_rx_flow i_ufc_rx_flow
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .spec_en(enhanced_features_r[5]),
        .sel(enhanced_features_r[3:0]),
        .chars(chars_r),
        .rx_valid(rx_valid),
        .rx_char(rx_char),
        .store_valid_r(store_valid_r),
        .store_char_r(store_char_r),
        .xoff_hit_r(xoff_hit),
        .xon_hit_r(xon_hit),
        .special_hit_r(special_hit)
    );

    ufc_tx_flow i_ufc_tx_flow
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .sel(enhanced_features_r[3:2]),
        .chars(chars_r),
        .send_pause(send_pause),
        .send_resume(send_resume),
        .flow_taken(flow_taken),
        .flow_valid_r(flow_valid_r),
        .flow_char_r(flow_char_r)
    );

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_fifo_off: assert property (wr_fifo && !wd[0] |=> ##1 fifo_depth_r == 7'h01 && rx_trig_r == 6'h01)
        else $error("fifo off not single char");
    a_fifo_on: assert property (wr_fifo && wd[0] |=> ##1 fifo_depth_r == 7'h40)
        else $error("fifo on depth not 64");
    a_txtrig_lock: assert property (wr_fifo && !unlock |=> $stable(tx_code_r))
        else $error("tx trigger changed while locked");
    a_efr_gate: assert property (req.wr && !enh_acc |=> $stable(enhanced_features_r))
        else $error("enhanced register written without key");
    a_cts_hold: assert property (enhanced_features_r[7] && cts_n_r |=> tx_hold_r)
        else $error("cts hold missing");
    a_rts_auto: assert property (enhanced_features_r[6] |=> rts_n_r == $past(rx_fifo_high))
        else $error("rts not following fifo level");
    a_ier_upper: assert property (wr_int_en && !unlock |=> $stable(interrupt_enable_r[7:4]))
        else $error("upper enables changed while locked");
    a_dlh_gate: assert property (req.wr && req.addr == 3'h1 && key |=> $stable(divisor_r))
        else $error("divisor written at key value");
    a_break_low: assert property (line_control_r[6] |=> !txd_r)
        else $error("break not driving line low");
    a_flag_clear: assert property (xon_hit && !xoff_hit |=> !xoff_flag_r)
        else $error("pause flag not cleared by resume");
endmodule
`default_nettype wire

//--- ufc_tx_flow.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_tx_flow
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] sel,
    input wire ufc_pkg::ufc_chars_s chars,
    input wire logic send_pause,
    input wire logic send_resume,
    input wire logic flow_taken,
    output logic flow_valid_r,
    output logic [7:0] flow_char_r
);
    import ufc_pkg::*;
    ufc_txst_e st_r;
    logic off_r;
    wire req = send_pause | send_resume;
    wire [7:0] c1 = send_pause ? chars.pause1 : chars.resume1;
    wire [7:0] c2 = send_pause ? chars.pause2 : chars.resume2;
    wire [7:0] c2_held = off_r ? chars.pause2 : chars.resume2;
    // ---------------------------------------------
    // flow character sender
    // ---------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_r <= UFC_TX_IDLE;
            off_r <= 1'b0;
            flow_valid_r <= 1'b0;
            flow_char_r <= 8'h00;
        end
        else
        begin
            case (st_r)
                UFC_TX_IDLE:
                    if (req && sel != 2'b00)
                    begin
                        st_r <= UFC_TX_FIRST;
                        off_r <= send_pause;
                        flow_valid_r <= 1'b1;
                        flow_char_r <= (sel == 2'b01) ? c2 : c1;
                    end
                UFC_TX_FIRST:
                    if (flow_taken)
                    begin
                        // second char follows at once, no gap
                        st_r <= (sel == 2'b11) ? UFC_TX_SECOND : UFC_TX_IDLE;
                        flow_valid_r <= sel == 2'b11;
                        flow_char_r <= c2_held;
                    end
                UFC_TX_SECOND:
                    if (flow_taken)
                    begin
                        st_r <= UFC_TX_IDLE;
                        flow_valid_r <= 1'b0;
                    end
                default:
                    st_r <= UFC_TX_IDLE;
            endcase
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_pair_order: assert property (st_r == UFC_TX_FIRST && flow_taken && sel == 2'b11 && off_r
        |=> flow_valid_r && flow_char_r == chars.pause2)
        else $error("second pause char not sent next");
    a_no_send: assert property (st_r == UFC_TX_IDLE && sel == 2'b00 |=> !flow_valid_r)
        else $error("flow char sent with transmit flow off");
endmodule
`default_nettype wire
